// ### core/dma_err_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz reference clock and word-aligned avalon addresses
`ifndef DMA_ERR_REGS_SVH
`define DMA_ERR_REGS_SVH
// ==========================================
// register byte offsets
`define CSR_OFS 4'h0
`define ERR_OFS 4'h4
`define VEC_OFS 4'h8
`define TMO_OFS 4'hC
// ==========================================
// control/status fields
`define CSR_GO 0
`define CSR_IE 6
`define CSR_RDY 7
`define CSR_ATTN 13
`define CSR_ERR 15
// ==========================================
// error flag fields
`define ERR_MULTI 0
`define ERR_PWR 1
`define ERR_UPWR 2
`define ERR_PAR 3
`define ERR_NORESP 4
`define ERR_AIRQ 5
`define ERR_AHOLD 6
// ==========================================
// reset values and timing counts
`define VEC_RST 8'h00
`define TMO_NS 12000
`define CLK_NS 20
`define TMO_CYC ((`TMO_NS) / (`CLK_NS))
`endif

// ### core/dma_err_pkg.sv
// types shared by the error and interrupt logic
// assumes nothing outside itself
package dma_err_pkg;
	// ==========================================
	// interrupt arbitration states
	typedef enum logic [2:0] {
		irq_idle,
		irq_request,
		irq_ack,
		irq_vector,
		irq_strobe,
		irq_finish
	} irq_state_e;
	// ==========================================
	// bus-side arbitration outputs
	typedef struct packed {
		logic [3:0] priority_request_to_selector;
		logic selection_ack_drive;
		logic busy_drive;
		logic interrupt_master_vector_drive;
		logic vector_strobe_request;
	} arb_out_s;
	// ==========================================
	// dma cycle status from the transfer logic
	typedef struct packed {
		logic master_sync;
		logic end_of_cycle_pulse;
		logic reading;
		logic cycle_active;
	} cyc_in_s;
endpackage

// ### core/dma_err_irq.sv
// error detection and interrupt request logic of a dma interface
// assumes an avalon-mm master, a dma cycle engine and a bus arbiter outside
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dma_err_regs.svh"

// Overview of operation
// - four error kinds exist; any one ends the current data block.
// - attention sets the combined error bit and ends the block like errors.
// - bus power-low sets power flag, finishes running cycle, then sets ready.
// - user-side power flag sets on power-low at any time.
// - both power flags clear only on initialisation or go.
// - parity line during a read sets parity flag, finishes cycle, becomes ready.
// - after parity or no-response error, address points one word beyond.
// - master sync starts response timer; expiry sets no-response flag, ends cycle.
// - response timeout defaults to about 12 us and is adjustable longer.
// - attention rising edge sets attention hold and attention interrupt flags.
// - read attention bit is live attention OR attention hold.
// - attention hold clears on initialisation, go, or writing attention bit 0.
// - attention interrupt flag sets on edge unless cleared; raises request when enabled.
// - attention interrupt clears on vector acknowledge, initialisation, go, or write 0.
// - request sets on ready with enable, go with error, attention while ready.
// - one request at a time; new request waits while still bus master.
// - request goes to one of four priority lines selected by plug.
// - on grant assert acknowledge, wait data idle, assert busy, drop acknowledge.
// - drive vector, then strobe; on slave sync end the transaction.
module dma_err_irq #(
	parameter int TMO_CYCLES = `TMO_CYC,
	parameter int TMO_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic i_init,
	input wire logic i_power_low,
	input wire logic i_parity_bad,
	input wire logic i_multicycle_err,
	input wire logic i_synced_user_attention,
	input wire dma_err_pkg::cyc_in_s i_cyc,
	input wire logic [1:0] i_level_sel,
	input wire logic [3:0] i_grant,
	input wire logic i_data_idle,
	input wire logic i_slave_sync,
	output dma_err_pkg::arb_out_s o_arb,
	output logic [7:0] o_vector,
	output logic o_force_complete,
	output logic o_ready,
	output logic o_user_power_fail,
	output logic o_go_pulse
);
	// ==========================================
	// bus slave decode
	logic wr_csr, wr_err, wr_vec, wr_tmo, rd_pend_r;
	logic [15:0] csr_wdata;
	assign csr_wdata = i_writedata[15:0];
	assign wr_csr = i_write && (i_address == `CSR_OFS);
	assign wr_err = i_write && (i_address == `ERR_OFS);
	assign wr_vec = i_write && (i_address == `VEC_OFS);
	assign wr_tmo = i_write && (i_address == `TMO_OFS);
	// reads take one wait state so data comes from a flop
	assign o_waitrequest = i_read && !rd_pend_r;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			rd_pend_r <= 1'b0;
		end else begin
			rd_pend_r <= i_read && !rd_pend_r;
		end
	end

	// ==========================================
	// control bits
	logic go, clr_all, ie_r, ready_r, attn_wr0;
	logic pwr_r, upwr_r, par_r, noresp_r, multi_r, ahold_r, airq_r;
	logic attn_d_r, attn_rise, any_err, err_bit, attn_bit, airq_clr;
	logic [7:0] vec_r;
	logic [TMO_W-1:0] tmo_lim_r;
	assign go = wr_csr && csr_wdata[`CSR_GO];
	assign clr_all = i_init || go;
	// software must write attention as 1 to avoid losing it
	assign attn_wr0 = wr_csr && !csr_wdata[`CSR_ATTN];
	assign attn_rise = i_synced_user_attention && !attn_d_r;
	assign attn_bit = i_synced_user_attention || ahold_r;
	// a clear held at the edge keeps the attention interrupt from setting
	assign airq_clr = clr_all || attn_wr0 || (o_arb.vector_strobe_request && i_slave_sync);
	assign any_err = multi_r || pwr_r || par_r || noresp_r;
	assign err_bit = any_err || attn_bit;
	assign o_go_pulse = go;
	assign o_ready = ready_r;
	assign o_user_power_fail = upwr_r;
	assign o_vector = vec_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ie_r <= 1'b0;
			vec_r <= `VEC_RST;
			tmo_lim_r <= TMO_W'(TMO_CYCLES);
		end else begin
			if (wr_csr) begin
				ie_r <= csr_wdata[`CSR_IE];
			end
			if (wr_vec) begin
				vec_r <= i_writedata[7:0];
			end
			if (wr_tmo && (i_writedata[TMO_W-1:0] >= TMO_W'(TMO_CYCLES))) begin
				tmo_lim_r <= i_writedata[TMO_W-1:0];
			end
		end
	end

	// ==========================================
	// response timer
	logic [TMO_W-1:0] tmo_cnt_r;
	logic tmo_run_r, tmo_hit;
	assign tmo_hit = tmo_run_r && (tmo_cnt_r == tmo_lim_r - TMO_W'(1));
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			tmo_run_r <= 1'b0;
			tmo_cnt_r <= '0;
		end else if (i_cyc.end_of_cycle_pulse || tmo_hit || !i_cyc.master_sync) begin
			tmo_run_r <= 1'b0;
			tmo_cnt_r <= '0;
		end else begin
			tmo_run_r <= 1'b1;
			tmo_cnt_r <= tmo_cnt_r + TMO_W'(tmo_run_r);
		end
	end
	// address increment happens in the cycle engine on completion
	assign o_force_complete = tmo_hit;

	// ==========================================
	// error flags: set wins over clear, except the attention interrupt flag, where clear wins
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			pwr_r <= 1'b0;
			upwr_r <= 1'b0;
		end else begin
			pwr_r <= i_power_low || (pwr_r && !clr_all);
			upwr_r <= i_power_low || (upwr_r && !clr_all);
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			par_r <= 1'b0;
			noresp_r <= 1'b0;
			multi_r <= 1'b0;
		end else begin
			par_r <= (i_parity_bad && i_cyc.reading && i_cyc.cycle_active) || (par_r && !clr_all);
			noresp_r <= tmo_hit || (noresp_r && !clr_all);
			multi_r <= i_multicycle_err || (multi_r && !clr_all);
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			attn_d_r <= 1'b0;
			ahold_r <= 1'b0;
			airq_r <= 1'b0;
		end else begin
			attn_d_r <= i_synced_user_attention;
			ahold_r <= attn_rise || (ahold_r && !(clr_all || attn_wr0));
			airq_r <= !airq_clr && (attn_rise || airq_r);
		end
	end

	// ==========================================
	// ready: block ends once the running cycle is done
	logic stop_pend;
	assign stop_pend = any_err || attn_bit;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ready_r <= 1'b1;
		end else if (go) begin
			ready_r <= 1'b0;
		end else if (i_init || (stop_pend && !i_cyc.cycle_active)) begin
			ready_r <= 1'b1;
		end
	end

	// ==========================================
	// interrupt request
	logic ready_d_r, irq_req_r, master;
	dma_err_pkg::irq_state_e st_r;
	assign master = (st_r != dma_err_pkg::irq_idle) && (st_r != dma_err_pkg::irq_request);
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			ready_d_r <= 1'b1;
			irq_req_r <= 1'b0;
		end else begin
			ready_d_r <= ready_r;
			if ((ready_r && !ready_d_r && ie_r) || (go && any_err) || (attn_rise && ready_r && ie_r)
				|| (attn_rise && ie_r && !airq_clr)) begin
				irq_req_r <= 1'b1;
			end else if (st_r == dma_err_pkg::irq_request && !master) begin
				irq_req_r <= 1'b0;
			end
		end
	end

	// ==========================================
	// arbitration sequencer, one request at a time
	logic grant_sel;
	assign grant_sel = i_grant[i_level_sel];
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b || i_init) begin
			st_r <= dma_err_pkg::irq_idle;
		end else begin
			case (st_r)
				dma_err_pkg::irq_idle: begin
					if (irq_req_r) begin
						st_r <= dma_err_pkg::irq_request;
					end
				end
				dma_err_pkg::irq_request: begin
					if (grant_sel) begin
						st_r <= dma_err_pkg::irq_ack;
					end
				end
				dma_err_pkg::irq_ack: begin
					if (i_data_idle && !i_slave_sync) begin
						st_r <= dma_err_pkg::irq_vector;
					end
				end
				dma_err_pkg::irq_vector: begin
					st_r <= dma_err_pkg::irq_strobe;
				end
				dma_err_pkg::irq_strobe: begin
					if (i_slave_sync) begin
						st_r <= dma_err_pkg::irq_finish;
					end
				end
				default: begin
					st_r <= dma_err_pkg::irq_idle;
				end
			endcase
		end
	end

	// ==========================================
	// arbitration outputs
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_arb <= '0;
		end else begin
			o_arb.priority_request_to_selector <= '0;
			if (st_r == dma_err_pkg::irq_request) begin
				o_arb.priority_request_to_selector[i_level_sel] <= 1'b1;
			end
			o_arb.selection_ack_drive <= (st_r == dma_err_pkg::irq_request && grant_sel)
				|| (st_r == dma_err_pkg::irq_ack && !(i_data_idle && !i_slave_sync));
			o_arb.busy_drive <= (st_r == dma_err_pkg::irq_ack && i_data_idle && !i_slave_sync)
				|| st_r == dma_err_pkg::irq_vector
				|| (st_r == dma_err_pkg::irq_strobe && !i_slave_sync);
			o_arb.interrupt_master_vector_drive <= (st_r == dma_err_pkg::irq_ack && i_data_idle && !i_slave_sync)
				|| st_r == dma_err_pkg::irq_vector
				|| (st_r == dma_err_pkg::irq_strobe && !i_slave_sync);
			o_arb.vector_strobe_request <= st_r == dma_err_pkg::irq_vector
				|| (st_r == dma_err_pkg::irq_strobe && !i_slave_sync);
		end
	end

	// ==========================================
	// read data
	logic [31:0] rd_nxt;
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (i_address == `CSR_OFS) begin
			rd_nxt[`CSR_IE] = ie_r;
			rd_nxt[`CSR_RDY] = ready_r;
			rd_nxt[`CSR_ATTN] = attn_bit;
			rd_nxt[`CSR_ERR] = err_bit;
		end else if (i_address == `ERR_OFS) begin
			rd_nxt[`ERR_MULTI] = multi_r;
			rd_nxt[`ERR_PWR] = pwr_r;
			rd_nxt[`ERR_UPWR] = upwr_r;
			rd_nxt[`ERR_PAR] = par_r;
			rd_nxt[`ERR_NORESP] = noresp_r;
			rd_nxt[`ERR_AIRQ] = airq_r;
			rd_nxt[`ERR_AHOLD] = ahold_r;
		end else if (i_address == `VEC_OFS) begin
			rd_nxt[7:0] = vec_r;
		end else if (i_address == `TMO_OFS) begin
			rd_nxt[TMO_W-1:0] = tmo_lim_r;
		end
	end
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_readdata <= 32'h0000_0000;
		end else if (i_read) begin
			o_readdata <= rd_nxt;
		end
	end
	// error register writes are ignored; flags are read-only
	logic unused_w;
	assign unused_w = wr_err;
endmodule

// ### testbench/dma_err_irq_sva.sv
// port checker for the error and interrupt block
// assumes one clock and a sync active-low reset
`timescale 1ns/1ps
module dma_err_irq_chk (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_init,
	input wire logic i_power_low,
	input wire logic [1:0] i_level_sel,
	input wire logic [3:0] i_grant,
	input wire logic i_data_idle,
	input wire logic i_slave_sync,
	input wire dma_err_pkg::arb_out_s o_arb,
	input wire logic o_force_complete,
	input wire logic o_ready,
	input wire logic o_user_power_fail,
	input wire logic o_go_pulse
);
	// ====
	// relations at the ports
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	a_upf_set: assert property (i_power_low |=> o_user_power_fail) else $error("upf late");
	a_upf_keep: assert property (o_user_power_fail && !o_go_pulse && !i_init |=> o_user_power_fail)
		else $error("upf lost");
	a_init_clear: assert property (i_init && !i_power_low && !o_go_pulse |=> !o_user_power_fail && o_ready)
		else $error("init no clear");
	a_tmo_ready: assert property (o_force_complete |-> ##[1:4] o_ready) else $error("no ready");
	a_one_line: assert property (|o_arb.priority_request_to_selector
		|-> o_arb.priority_request_to_selector == 4'h1 << i_level_sel) else $error("bad line");
	a_single_req: assert property (o_arb.busy_drive |-> !(|o_arb.priority_request_to_selector))
		else $error("two requests");
	a_ack_grant: assert property ($rose(o_arb.selection_ack_drive) |-> $past(i_grant[i_level_sel]))
		else $error("ack no grant");
	a_busy_swap: assert property ($rose(o_arb.busy_drive) |-> !o_arb.selection_ack_drive && $past(i_data_idle))
		else $error("bad busy");
	a_vec_first: assert property ($rose(o_arb.vector_strobe_request)
		|-> $past(o_arb.interrupt_master_vector_drive)) else $error("strobe early");
	a_strobe_hold: assert property (o_arb.vector_strobe_request && !i_slave_sync
		|=> o_arb.vector_strobe_request) else $error("strobe drop");
	a_txn_end: assert property (o_arb.vector_strobe_request && i_slave_sync
		|=> !o_arb.busy_drive && !o_arb.vector_strobe_request) else $error("no end");
endmodule
bind dma_err_irq dma_err_irq_chk i_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_init(i_init),
	.i_power_low(i_power_low),
	.i_level_sel(i_level_sel), .i_grant(i_grant), .i_data_idle(i_data_idle), .i_slave_sync(i_slave_sync),
	.o_arb(o_arb), .o_force_complete(o_force_complete), .o_ready(o_ready),
	.o_user_power_fail(o_user_power_fail), .o_go_pulse(o_go_pulse));

// ### testbench/bus_partner.sv
// processor and arbiter stand-in on the interrupt link
// assumes the plug selection is steady during a request
`timescale 1ns/1ps
module bus_partner (
	input wire logic i_ref_clk,
	input wire logic i_slow,
	input wire logic [1:0] i_level_sel,
	input wire dma_err_pkg::arb_out_s i_arb,
	input wire logic [7:0] i_vector,
	output logic [3:0] o_grant,
	output logic o_data_idle,
	output logic o_slave_sync,
	output logic [7:0] o_vec_seen
);
	int held = 0;
	initial begin
		{o_grant, o_data_idle, o_slave_sync, o_vec_seen} = 14'h0000;
	end
	// slow mode keeps the data section busy for a while
	always @(posedge i_ref_clk) begin
		held <= i_arb.selection_ack_drive ? held + 1 : 0;
		o_data_idle <= !i_slow || held > 4;
		o_grant <= (i_arb.priority_request_to_selector[i_level_sel] && !i_arb.selection_ack_drive)
			? 4'h1 << i_level_sel : 4'h0;
		o_slave_sync <= i_arb.vector_strobe_request;
		if (i_arb.vector_strobe_request && i_arb.interrupt_master_vector_drive)
			o_vec_seen <= i_vector;
	end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the error and interrupt block
// assumes the partner model and the bound checker
`timescale 1ns/1ps
module tb_top;
	logic clk, rst_b, rd, wr, init, pwr, par, mul, attn, idle, ssync, fc, rdy, upf, go, slow, wrq;
	logic [3:0] adr, gnt;
	logic [31:0] wd, rdat, q;
	logic [1:0] sel;
	logic [7:0] vec, vseen;
	dma_err_pkg::cyc_in_s cyc;
	dma_err_pkg::arb_out_s arb;
	int num_errors = 0;
	int checks_done = 0;
	int n;
	dma_err_irq #(.TMO_CYCLES(8)) i_dma_err_irq (.i_ref_clk(clk), .i_rst_b(rst_b), .i_address(adr),
		.i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdat), .o_waitrequest(wrq), .i_init(init),
		.i_power_low(pwr), .i_parity_bad(par), .i_multicycle_err(mul), .i_synced_user_attention(attn),
		.i_cyc(cyc), .i_level_sel(sel), .i_grant(gnt), .i_data_idle(idle), .i_slave_sync(ssync), .o_arb(arb),
		.o_vector(vec), .o_force_complete(fc), .o_ready(rdy), .o_user_power_fail(upf), .o_go_pulse(go));
	bus_partner i_bus_partner (.i_ref_clk(clk), .i_slow(slow), .i_level_sel(sel), .i_arb(arb),
		.i_vector(vec), .o_grant(gnt), .o_data_idle(idle), .o_slave_sync(ssync), .o_vec_seen(vseen));
	// ====
	// shared tasks
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		n++;
		if (n > 2000) begin
			num_errors++;
			complete_run;
		end
	endtask
	// request rises after an edge, holds until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		n = 0;
		tick;
		{adr, wd, wr, rd} <= {a, d, w, !w};
		do tick; while (wrq !== 1'h0);
		q = rdat;
		{wr, rd} <= 2'h0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		chk(q & m, e);
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		{pwr, par, mul, attn} <= m;
		@(posedge clk);
		{pwr, par, mul, attn} <= 4'h0;
	endtask
	task automatic init_pulse;
		@(posedge clk);
		init <= 1'h1;
		@(posedge clk);
		init <= 1'h0;
	endtask
	// ====
	// scenarios
	task automatic t_regs;
		rdchk(4'h4, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(1'h1, 4'h4, 32'h0000_007F);
		rdchk(4'h4, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(1'h1, 4'h2, 32'hFFFF_FFFF);
		rdchk(4'h2, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask
	task automatic t_power;
		pulse(4'h8);
		@(negedge clk);
		chk(upf, 1'h1);
		init_pulse;
		@(negedge clk);
		chk(upf, 1'h0);
		pulse(4'h8);
		rdchk(4'h4, 32'h0000_0006, 32'h0000_0006);
		rdchk(4'h0, 32'h0000_8080, 32'h0000_8080);
		bus(1'h1, 4'h0, 32'h0000_2001);
		@(negedge clk);
		chk(upf, 1'h0);
		rdchk(4'h4, 32'h0000_0006, 32'h0000_0000);
	endtask
	task automatic t_parity;
		@(posedge clk);
		cyc <= 4'h3;
		pulse(4'h4);
		cyc <= 4'h0;
		n = 0;
		while (rdy !== 1'h1) tick;
		rdchk(4'h4, 32'h0000_0008, 32'h0000_0008);
	endtask
	task automatic t_noresp;
		bus(1'h1, 4'h0, 32'h0000_2001);
		cyc <= 4'h9;
		n = 0;
		do tick; while (fc !== 1'h1);
		chk(n >= 8 && n <= 11, 1'h1);
		cyc <= 4'h0;
		rdchk(4'h4, 32'h0000_0010, 32'h0000_0010);
		chk(rdy, 1'h1);
		bus(1'h1, 4'hC, 32'h0000_0004);
		rdchk(4'hC, 32'h0000_FFFF, 32'h0000_0008);
		bus(1'h1, 4'hC, 32'h0000_0010);
		rdchk(4'hC, 32'h0000_FFFF, 32'h0000_0010);
	endtask
	task automatic t_multi;
		pulse(4'h2);
		rdchk(4'h4, 32'h0000_0001, 32'h0000_0001);
	endtask
	task automatic t_attn;
		init_pulse;
		pulse(4'h1);
		rdchk(4'h0, 32'h0000_A080, 32'h0000_A080);
		rdchk(4'h4, 32'h0000_007F, 32'h0000_0060);
		bus(1'h1, 4'h0, 32'h0000_0000);
		rdchk(4'h4, 32'h0000_0060, 32'h0000_0000);
		attn <= 1'h1;
		bus(1'h1, 4'h0, 32'h0000_0000);
		rdchk(4'h0, 32'h0000_2000, 32'h0000_2000);
		attn <= 1'h0;
		rdchk(4'h0, 32'h0000_2000, 32'h0000_0000);
	endtask
	task automatic t_irq;
		for (int s = 0; s < 4; s++) begin
			sel <= s[1:0];
			slow <= s[0];
			bus(1'h1, 4'h8, 32'h0000_00A0 + s);
			bus(1'h1, 4'h0, 32'h0000_2040);
			pulse(4'h1);
			n = 0;
			do tick; while (arb.vector_strobe_request !== 1'h1);
			do tick; while (arb.busy_drive !== 1'h0);
			chk(vseen, 32'h0000_00A0 + s);
			rdchk(4'h4, 32'h0000_0060, 32'h0000_0040);
		end
	endtask
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		{rst_b, rd, wr, init, pwr, par, mul, attn, slow} = 9'h000;
		{adr, wd, sel, cyc} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		t_regs;
		t_power;
		t_parity;
		t_noresp;
		t_multi;
		t_attn;
		t_irq;
		complete_run;
	end
endmodule
